// ===== hw/adc_done_flags.v
// Overview of operation
// - A finished conversion sets the flag whose index is its slot position.
// - The low status byte shows flags 7 to 0 in bits 7 to 0.
// - The high status byte shows flags 15 to 8 in bits 7 to 0.
// - Any sequence start write clears every completion flag.
// - With fast clear off a flag clears on a status read then a result read.
// - With fast clear on a result read alone clears its flag.
// - A sequence start clear beats a simultaneous set.
// - A simultaneous set beats a read-triggered clear.
// - A flag of one means that slot has finished and its result is ready.
// - Writes to the status bytes are ignored; reads return current flags.
// - Each input enable bit gates the pin's digital buffer, one enables.
// - An enabled buffer stays on even while the pin is converted.
// - A port bit returns the pin level if enabled or trigger, else one.
`timescale 1ns/1ps
`default_nettype none
`include "adc_flags_map.vh"
module adc_done_flags (
   input wire mclk_i,
   input wire rstn_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire [15:0] slot_done_i,
   input wire seq_start_i,
   input wire [15:0] result_read_i,
   input wire [15:0] pin_level_i,
   input wire [15:0] trigger_pin_i,
   output wire [15:0] buffer_enable_o,
   output wire [15:0] port_input_o,
   output wire fast_flag_clear_mode_o,
   output wire irq_o
);
   reg [7:0] digital_input_enable_high;
   reg [7:0] digital_input_enable_low;
   reg [7:0] control;
   reg [7:0] irq_status;
   reg [7:0] irq_mask;
   reg [7:0] next_rdata;
   wire [15:0] flags;
   wire [15:0] input_enable;
   wire [15:0] port_value;
   wire rd_low;
   wire rd_high;
   wire ctl_wr;
   wire start_clear;
   wire ev_any;
   wire ev_all;
   assign input_enable = {digital_input_enable_high, digital_input_enable_low};
   assign rd_low = rd_i & (addr_i == `OFS_DONE_LOW);
   assign rd_high = rd_i & (addr_i == `OFS_DONE_HIGH);
   assign ctl_wr = wr_i & (addr_i == `OFS_CONTROL);
   // sequencer start write pulse arrives on seq_start_i
   assign start_clear = seq_start_i;
   assign fast_flag_clear_mode_o = control[`CTL_FAST_CLEAR_BIT];
   // buffer enable is never forced off by conversion activity
   assign buffer_enable_o = input_enable;
   assign irq_o = |(irq_status & irq_mask);

   genvar i;
   generate
      for (i = 0; i < `NUM_FLAGS; i = i + 1) begin : g_flag
         done_flag_cell u_cell (
            .mclk_i(mclk_i),
            .rstn_i(rstn_i),
            .set_i(slot_done_i[i]),
            .start_clear_i(start_clear),
            .status_read_i((i < 8) ? rd_low : rd_high),
            .result_read_i(result_read_i[i]),
            .fast_clear_i(control[`CTL_FAST_CLEAR_BIT]),
            .flag_o(flags[i])
         );
      end
   endgenerate

   port_input_gate u_gate (
      .pin_level_i(pin_level_i),
      .input_enable_i(input_enable),
      .trigger_pin_i(trigger_pin_i),
      .port_value_o(port_value)
   );
   assign port_input_o = port_value;

   assign ev_any = |slot_done_i;
   assign ev_all = slot_done_i[15];

   always @* begin
      next_rdata = 8'h00;
      case (addr_i)
         `OFS_DONE_LOW: next_rdata = flags[7:0];
         `OFS_DONE_HIGH: next_rdata = flags[15:8];
         `OFS_ENABLE_HIGH: next_rdata = digital_input_enable_high;
         `OFS_ENABLE_LOW: next_rdata = digital_input_enable_low;
         `OFS_PORT_HIGH: next_rdata = port_value[15:8];
         `OFS_PORT_LOW: next_rdata = port_value[7:0];
         `OFS_CONTROL: next_rdata = control;
         `OFS_IRQ_STATUS: next_rdata = irq_status;
         `OFS_IRQ_MASK: next_rdata = irq_mask;
         default: next_rdata = 8'h00;
      endcase
   end

   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         digital_input_enable_high <= `RST_ENABLE;
         digital_input_enable_low <= `RST_ENABLE;
         control <= `RST_CONTROL;
         irq_status <= `RST_IRQ;
         irq_mask <= `RST_IRQ;
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rd_i ? next_rdata : 8'h00;
         // status bytes have no write path
         if (wr_i & (addr_i == `OFS_ENABLE_HIGH))
            digital_input_enable_high <= wdata_i;
         if (wr_i & (addr_i == `OFS_ENABLE_LOW))
            digital_input_enable_low <= wdata_i;
         if (ctl_wr)
            control <= {7'h00, wdata_i[`CTL_FAST_CLEAR_BIT]};
         if (wr_i & (addr_i == `OFS_IRQ_MASK))
            irq_mask <= {6'h00, wdata_i[1:0]};
         // set wins over write-one-to-clear
         if (wr_i & (addr_i == `OFS_IRQ_STATUS))
            irq_status <= (irq_status & ~wdata_i & 8'h03) |
                          {6'h00, ev_all, ev_any};
         else
            irq_status <= irq_status | {6'h00, ev_all, ev_any};
      end
   end
endmodule // adc_done_flags
`default_nettype wire

// ===== hw/adc_flags_map.vh
`ifndef ADC_FLAGS_MAP_VH
`define ADC_FLAGS_MAP_VH
// register byte offsets on the plain register port
`define OFS_DONE_LOW 8'h00
`define OFS_DONE_HIGH 8'h01
`define OFS_ENABLE_HIGH 8'h02
`define OFS_ENABLE_LOW 8'h03
`define OFS_PORT_HIGH 8'h04
`define OFS_PORT_LOW 8'h05
`define OFS_CONTROL 8'h06
`define OFS_IRQ_STATUS 8'h07
`define OFS_IRQ_MASK 8'h08
// control register fields
`define CTL_FAST_CLEAR_BIT 0
// irq status fields
`define IRQ_ANY_DONE_BIT 0
`define IRQ_ALL_DONE_BIT 1
// reset values
`define RST_ENABLE 8'h00
`define RST_CONTROL 8'h00
`define RST_IRQ 8'h00
`define NUM_FLAGS 16
`endif

// ===== hw/done_flag_cell.v
`timescale 1ns/1ps
`default_nettype none
module done_flag_cell (
   input wire mclk_i,
   input wire rstn_i,
   input wire set_i,
   input wire start_clear_i,
   input wire status_read_i,
   input wire result_read_i,
   input wire fast_clear_i,
   output wire flag_o
);
   reg flag;
   reg armed;
   wire read_clear;
   assign read_clear = result_read_i & (fast_clear_i | armed);
   assign flag_o = flag;
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag <= 1'b0;
         armed <= 1'b0;
      end else begin
         if (start_clear_i)
            flag <= 1'b0;
         else if (set_i)
            flag <= 1'b1;
         else if (read_clear)
            flag <= 1'b0;
         // arming tracks only a status read seen while the flag was up
         if (start_clear_i | read_clear | set_i)
            armed <= 1'b0;
         else if (status_read_i & flag)
            armed <= 1'b1;
      end
   end
endmodule // done_flag_cell
`default_nettype wire

// ===== hw/port_input_gate.v
`timescale 1ns/1ps
`default_nettype none
module port_input_gate (
   input wire [15:0] pin_level_i,
   input wire [15:0] input_enable_i,
   input wire [15:0] trigger_pin_i,
   output wire [15:0] port_value_o
);
   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_bit
         // disabled buffer reads as one unless the pin is a trigger pin
         assign port_value_o[i] = (input_enable_i[i] | trigger_pin_i[i]) ?
                                  pin_level_i[i] : 1'b1;
      end
   endgenerate
endmodule // port_input_gate
`default_nettype wire

// ===== dv/adc_done_flags_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module adc_done_flags_monitor (
   input wire mclk_i,
   input wire rstn_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire [15:0] slot_done_i,
   input wire seq_start_i,
   input wire [15:0] result_read_i,
   input wire [15:0] pin_level_i,
   input wire [15:0] trigger_pin_i,
   input wire [15:0] buffer_enable_o,
   input wire [15:0] port_input_o,
   input wire fast_flag_clear_mode_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   wire [15:0] gate = buffer_enable_o | trigger_pin_i;
   idle_rdata_a:
      assert property (!rd_i |=> rdata_o == 8'h00) else $error("stray read data");
   start_clear_a:
      assert property (seq_start_i ##1 !(|slot_done_i) ##1 (rd_i && addr_i < 8'h02)
         |=> rdata_o == 8'h00) else $error("flags kept over start");
   low_set_a:
      assert property (slot_done_i[0] && !seq_start_i ##1 !seq_start_i && !result_read_i[0]
         ##1 (rd_i && addr_i == 8'h00) |=> rdata_o[0]) else $error("flag 0 not set");
   high_set_a:
      assert property (slot_done_i[15] && !seq_start_i ##1 !seq_start_i && !result_read_i[15]
         ##1 (rd_i && addr_i == 8'h01) |=> rdata_o[7]) else $error("flag 15 not set");
   fast_clear_a:
      assert property (fast_flag_clear_mode_o && result_read_i[2] && !slot_done_i[2]
         ##1 !slot_done_i[2] ##1 (rd_i && addr_i == 8'h00) |=> !rdata_o[2])
         else $error("fast clear missed");
   ien_write_a:
      assert property (wr_i && addr_i == 8'h03 |=> buffer_enable_o[7:0] == $past(wdata_i))
         else $error("enable write lost");
   ien_hold_a:
      assert property (!wr_i |=> $stable(buffer_enable_o)) else $error("enable drifted");
   port_gate_a:
      assert property (port_input_o == ((pin_level_i & gate) | ~gate)) else $error("port gate");
endmodule // adc_done_flags_monitor
bind adc_done_flags adc_done_flags_monitor mon (
   .mclk_i(mclk_i),
   .rstn_i(rstn_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .slot_done_i(slot_done_i),
   .seq_start_i(seq_start_i),
   .result_read_i(result_read_i),
   .pin_level_i(pin_level_i),
   .trigger_pin_i(trigger_pin_i),
   .buffer_enable_o(buffer_enable_o),
   .port_input_o(port_input_o),
   .fast_flag_clear_mode_o(fast_flag_clear_mode_o)
);
`default_nettype wire

// ===== dv/adc_done_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module adc_done_flags_tb;
   logic mclk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, seq_start_i = 0;
   logic fast_flag_clear_mode_o, irq_o;
   logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
   logic [15:0] slot_done_i = 0, result_read_i = 0, pin_level_i = 0, trigger_pin_i = 0;
   logic [15:0] buffer_enable_o, port_input_o;
   int mismatches = 0, n_compared = 0;
   adc_done_flags dut (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .slot_done_i(slot_done_i),
      .seq_start_i(seq_start_i),
      .result_read_i(result_read_i),
      .pin_level_i(pin_level_i),
      .trigger_pin_i(trigger_pin_i),
      .buffer_enable_o(buffer_enable_o),
      .port_input_o(port_input_o),
      .fast_flag_clear_mode_o(fast_flag_clear_mode_o),
      .irq_o(irq_o)
   );
   initial forever #5 mclk_i = ~mclk_i;
   task summarize;
      if (mismatches == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task wr(input [7:0] a, d);
      @(posedge mclk_i);
      {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task rc(input [7:0] a, e);
      @(posedge mclk_i);
      {addr_i, rd_i} <= {a, 1'b1};
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 `CHK("rdata", e, rdata_o)
   endtask
   task ev(input [15:0] s, r, input st);
      @(posedge mclk_i);
      {slot_done_i, result_read_i, seq_start_i} <= {s, r, st};
      @(posedge mclk_i);
      {slot_done_i, result_read_i, seq_start_i} <= '0;
   endtask
   task t_two_step;
      ev(16'h8101, 16'h0000, 1'b0);
      rc(8'h00, 8'h01);
      ev(16'h0000, 16'h0100, 1'b0);
      rc(8'h01, 8'h81);
      wr(8'h01, 8'hff);
      rc(8'h01, 8'h81);
      ev(16'h0000, 16'h0101, 1'b0);
      rc(8'h00, 8'h00);
      rc(8'h01, 8'h80);
   endtask
   task t_start;
      ev(16'h0002, 16'h0000, 1'b1);
      rc(8'h00, 8'h00);
      rc(8'h01, 8'h00);
      ev(16'h8000, 16'h0000, 1'b0);
      rc(8'h01, 8'h80);
   endtask
   task t_fast;
      wr(8'h06, 8'h01);
      #1 `CHK("fast mode", 1'b1, fast_flag_clear_mode_o)
      ev(16'h0004, 16'h0000, 1'b0);
      ev(16'h0000, 16'h0004, 1'b0);
      rc(8'h00, 8'h00);
      ev(16'h0008, 16'h0008, 1'b0);
      rc(8'h00, 8'h08);
      wr(8'h06, 8'h00);
      #1 `CHK("fast mode", 1'b0, fast_flag_clear_mode_o)
   endtask
   task t_enable;
      wr(8'h02, 8'ha5);
      {pin_level_i, trigger_pin_i} <= {16'h0f0d, 16'h0002};
      wr(8'h03, 8'h3c);
      rc(8'h02, 8'ha5);
      rc(8'h03, 8'h3c);
      rc(8'h3f, 8'h00);
      `CHK("buffer", 16'ha53c, buffer_enable_o)
      `CHK("port", 16'h5fcd, port_input_o)
      rc(8'h04, 8'h5f);
      rc(8'h05, 8'hcd);
   endtask
   task t_irq;
      wr(8'h08, 8'h01);
      rc(8'h07, 8'h03);
      `CHK("irq", 1'b1, irq_o)
      wr(8'h07, 8'h03);
      wr(8'h08, 8'h02);
      ev(16'h0001, 16'h0000, 1'b0);
      rc(8'h07, 8'h01);
      `CHK("irq", 1'b0, irq_o)
   endtask
   initial begin
      repeat (10) @(posedge mclk_i);
      rstn_i <= 1'b1;
      #1 `CHK("port", 16'hffff, port_input_o)
      t_two_step;
      t_start;
      t_fast;
      t_enable;
      t_irq;
      summarize;
   end
   // whole run needs some 80 cycles
   initial begin
      #20us;
      mismatches++;
      summarize;
   end
endmodule // adc_done_flags_tb
`default_nettype wire
